// >>> core/cis_pkg.sv
package cis_pkg;

    localparam int          WORD_W     = 16;
    localparam int          NUM_REGS   = 16;
    localparam int          STACK_AW   = 8;
    localparam logic [15:0] PC_RESET   = 16'h0000;
    localparam logic [15:0] SP_RESET   = 16'hFC00;
    localparam logic [7:0]  CSP_RESET  = 8'h00;
    localparam logic [15:0] STACK_STEP = 16'h0002;
    localparam logic [15:0] LEN_SHORT  = 16'h0002;
    localparam logic [15:0] LEN_LONG   = 16'h0004;
    localparam int          SIGN_BIT   = 7;
    localparam int          TRAP_SHIFT = 2;

    // Decoded operation, the binary encoding is owned by the fetch/decode stage
    typedef enum logic [4:0] {
        CIS_NOP,
        CIS_MOV,
        CIS_BYTE_TO_WORD_SIGNED_MOVE,
        CIS_BYTE_TO_WORD_UNSIGNED_MOVE,
        CIS_BRANCH_BIT_SET,
        CIS_BRANCH_BIT_CLEAR,
        CIS_BRANCH_AND_CLEAR_BIT,
        CIS_BRANCH_AND_SET_BIT,
        CIS_BRANCH_ABS,
        CIS_BRANCH_IND,
        CIS_BRANCH_REL,
        CIS_INTER_SEGMENT_BRANCH,
        CIS_ENTRY_ABS,
        CIS_ENTRY_IND,
        CIS_ENTRY_REL,
        CIS_FAR_SUBROUTINE_ENTRY,
        CIS_PUSH_THEN_SUBROUTINE_ENTRY,
        CIS_CONTEXT_SWITCH_PUSH_LOAD,
        CIS_PUSH,
        CIS_POP,
        CIS_NEAR_SUBROUTINE_EXIT,
        CIS_FAR_SUBROUTINE_EXIT,
        CIS_SUBROUTINE_EXIT_WITH_POP,
        CIS_SOFTWARE_TRAP,
        CIS_POWER_DOWN_ENTRY,
        CIS_END_OF_INIT_SIGNAL,
        CIS_REGISTER_SPACE_PREFIX,
        CIS_PAGE_OVERRIDE_PREFIX,
        CIS_SEGMENT_OVERRIDE_PREFIX
    } cis_op_t;

    typedef struct packed {
        cis_op_t     op;
        logic        long_form;
        logic        cond_met;
        logic [3:0]  reg_idx;
        logic [3:0]  bit_idx;
        logic [7:0]  rel;
        logic [15:0] target;
        logic [7:0]  segment;
        logic [15:0] imm;
        logic [6:0]  trap_num;
        logic [2:0]  seq_len;
        logic        with_reg;
    } cis_instr_t;

    typedef struct packed {
        logic        active;
        logic        page;
        logic        segment;
        logic        reg_ext;
        logic [15:0] value;
        logic [2:0]  left;
    } cis_ovr_t;

endpackage

// >>> core/cis_stack_mem.sv
`timescale 1ns/10ps
`default_nettype none

module cis_stack_mem #(
    parameter int AW = 8
) (
    // Clock and reset
    input  wire logic          ref_clk_in,
    input  wire logic          sys_rst_in,
    // Access port
    input  wire logic          wr_en_in,
    input  wire logic          rd_en_in,
    input  wire logic [AW-1:0] addr_in,
    input  wire logic [15:0]   wr_data_in,
    output logic      [15:0]   rd_data_out
);

    logic [15:0] mem [2**AW];
    logic [15:0] next_rd_data;

    always_comb begin
        next_rd_data = rd_data_out;
        if (rd_en_in) begin
            next_rd_data = mem[addr_in];
        end
    end

    always_ff @(posedge ref_clk_in) begin
        if (wr_en_in) begin
            mem[addr_in] <= wr_data_in;
        end
        if (sys_rst_in) begin
            rd_data_out <= 16'h0000;
        end else begin
            rd_data_out <= next_rd_data;
        end
    end

endmodule

`default_nettype wire

// >>> core/cis_exec.sv
// Functional notes
// RULE_01: Signed byte move copies byte to word, bit 7 fills upper byte.
// RULE_02: Unsigned byte move copies byte to word, upper byte forced zero.
// RULE_03: Branch-and-clear: if bit is one, clear it and branch relative.
// RULE_04: Branch-and-set: if bit is zero, set it and branch relative.
// RULE_05: Bit-test branches jump on set or clear bit, bit left unchanged.
// RULE_06: Absolute, indirect, relative branches jump only when condition true.
// RULE_07: Inter-segment branch loads new code segment and offset unconditionally.
// RULE_08: Conditional entries push return address and branch only when condition holds.
// RULE_09: Far entry saves segment and return offset, branches into any segment.
// RULE_10: Push-then-entry pushes a register, then return address, then branches.
// RULE_11: Context switch pushes a register then loads it with the operand.
// RULE_12: Push and pop move one register to or from stack, adjusting pointer.
// RULE_13: Exit with pop restores return offset then pops a register.
// RULE_14: Far exit restores offset and segment; near exit restores offset only.
// RULE_15: Software trap vectors to routine chosen by immediate trap number.
// RULE_16: Power-down entry takes effect only while the NMI pin is low.
// RULE_17: End-of-init changes the level of the reset output pin.
// RULE_18: Page and segment prefixes open an override sequence for data accesses.
// RULE_19: Register-space prefix makes short addresses use extended register space.
// RULE_20: Opcode encodings come from the decoder; this unit takes decoded operations.
`timescale 1ns/10ps
`default_nettype none

module cis_exec #(
    parameter int STACK_AW = cis_pkg::STACK_AW
) (
    // Clock and reset
    input  wire logic               ref_clk_in,
    input  wire logic               sys_rst_in,
    // Decoded instruction
    input  wire logic               instr_valid_in,
    input  wire cis_pkg::cis_instr_t instr_in,
    output logic                    instr_ready_out,
    // Pins
    input  wire logic               nmi_n_in,
    output logic                    reset_output_pin_n_out,
    output logic                    power_down_out,
    // Core state
    output logic      [15:0]        pc_out,
    output logic      [7:0]         csp_out,
    output logic      [15:0]        sp_out,
    output cis_pkg::cis_ovr_t       ovr_out,
    // Register observation
    input  wire logic [3:0]         reg_rd_idx_in,
    output logic      [15:0]        reg_rd_data_out
);

    typedef enum logic [1:0] {
        ST_IDLE,
        ST_PUSH_IP,
        ST_POP1,
        ST_POP2
    } cis_state_t;

    cis_state_t         st;
    cis_state_t         next_st;
    logic [15:0]        pc;
    logic [15:0]        next_pc;
    logic [7:0]         csp;
    logic [7:0]         next_csp;
    logic [15:0]        sp;
    logic [15:0]        next_sp;
    logic [15:0]        regs [cis_pkg::NUM_REGS];
    logic [15:0]        next_regs [cis_pkg::NUM_REGS];
    logic [15:0]        ret_ip;
    logic [15:0]        next_ret_ip;
    cis_pkg::cis_op_t   pend_op;
    cis_pkg::cis_op_t   next_pend_op;
    logic [3:0]         pend_reg;
    logic [3:0]         next_pend_reg;
    logic               pwr;
    logic               next_pwr;
    logic               init_done;
    logic               next_init_done;
    cis_pkg::cis_ovr_t  ovr;
    cis_pkg::cis_ovr_t  next_ovr;
    logic [15:0]        next_reg_rd;
    logic               nmi_meta;
    logic               nmi_sync;
    // Stack port
    logic               mem_wr;
    logic               mem_rd;
    logic [15:0]        mem_byte_addr;
    logic [15:0]        mem_wdata;
    logic [15:0]        mem_rdata;

    cis_stack_mem #(
        .AW (STACK_AW)
    ) u_stack (
        .ref_clk_in  (ref_clk_in),
        .sys_rst_in  (sys_rst_in),
        .wr_en_in    (mem_wr),
        .rd_en_in    (mem_rd),
        .addr_in     (mem_byte_addr[STACK_AW:1]),
        .wr_data_in  (mem_wdata),
        .rd_data_out (mem_rdata)
    );

    cis_pkg::cis_instr_t i;
    logic [15:0]         len;
    logic [15:0]         seq_pc;
    logic [15:0]         rel_pc;
    logic                bitv;
    logic [7:0]          byte_op;
    logic                accept;

    assign i               = instr_in;
    assign instr_ready_out = (st == ST_IDLE) && !pwr;
    assign accept          = instr_valid_in && instr_ready_out;
    assign pc_out          = pc;
    assign csp_out         = csp;
    assign sp_out          = sp;
    assign ovr_out         = ovr;
    assign power_down_out  = pwr;
    assign reset_output_pin_n_out = init_done;

    always_comb begin
        next_st        = st;
        next_pc        = pc;
        next_csp       = csp;
        next_sp        = sp;
        next_regs      = regs;
        next_ret_ip    = ret_ip;
        next_pend_op   = pend_op;
        next_pend_reg  = pend_reg;
        next_pwr       = pwr;
        next_init_done = init_done;
        next_ovr       = ovr;
        next_reg_rd    = regs[reg_rd_idx_in];
        mem_wr         = 1'b0;
        mem_rd         = 1'b0;
        mem_byte_addr  = sp;
        mem_wdata      = 16'h0000;
        byte_op        = i.imm[7:0];
        bitv           = regs[i.reg_idx][i.bit_idx];
        // Moves and page/segment override prefixes may be short or long
        unique case (i.op)
            cis_pkg::CIS_MOV,
            cis_pkg::CIS_BYTE_TO_WORD_SIGNED_MOVE,
            cis_pkg::CIS_BYTE_TO_WORD_UNSIGNED_MOVE,
            cis_pkg::CIS_PAGE_OVERRIDE_PREFIX,
            cis_pkg::CIS_SEGMENT_OVERRIDE_PREFIX: begin
                len = i.long_form ? cis_pkg::LEN_LONG : cis_pkg::LEN_SHORT;
            end
            cis_pkg::CIS_PUSH,
            cis_pkg::CIS_POP,
            cis_pkg::CIS_NEAR_SUBROUTINE_EXIT,
            cis_pkg::CIS_FAR_SUBROUTINE_EXIT,
            cis_pkg::CIS_SUBROUTINE_EXIT_WITH_POP,
            cis_pkg::CIS_SOFTWARE_TRAP,
            cis_pkg::CIS_REGISTER_SPACE_PREFIX,
            cis_pkg::CIS_NOP: begin
                len = cis_pkg::LEN_SHORT;
            end
            default: begin
                len = cis_pkg::LEN_LONG;
            end
        endcase
        seq_pc = pc + len;
        rel_pc = seq_pc + {{7{i.rel[7]}}, i.rel, 1'b0};

        unique case (st)
            ST_IDLE: begin
                if (accept) begin
                    next_pc = seq_pc;
                    // Override counts only instructions after the prefix
                    if (ovr.active) begin
                        next_ovr.left = ovr.left - 3'h1;
                        if (ovr.left == 3'h1) begin
                            next_ovr.active = 1'b0;
                        end
                    end
                    unique case (i.op) // RULE_20
                        cis_pkg::CIS_MOV: begin
                            next_regs[i.reg_idx] = i.imm;
                        end
                        cis_pkg::CIS_BYTE_TO_WORD_SIGNED_MOVE: begin // RULE_01
                            next_regs[i.reg_idx] = {{8{byte_op[cis_pkg::SIGN_BIT]}}, byte_op};
                        end
                        cis_pkg::CIS_BYTE_TO_WORD_UNSIGNED_MOVE: begin
                            next_regs[i.reg_idx] = {8'h00, byte_op}; // RULE_02
                        end
                        cis_pkg::CIS_BRANCH_BIT_SET: begin
                            if (bitv) next_pc = rel_pc; // RULE_05
                        end
                        cis_pkg::CIS_BRANCH_BIT_CLEAR: begin
                            if (!bitv) next_pc = rel_pc; // RULE_05
                        end
                        cis_pkg::CIS_BRANCH_AND_CLEAR_BIT: begin
                            if (bitv) begin
                                next_regs[i.reg_idx][i.bit_idx] = 1'b0; // RULE_03
                                next_pc = rel_pc; // RULE_03
                            end
                        end
                        cis_pkg::CIS_BRANCH_AND_SET_BIT: begin
                            if (!bitv) begin
                                next_regs[i.reg_idx][i.bit_idx] = 1'b1; // RULE_04
                                next_pc = rel_pc; // RULE_04
                            end
                        end
                        cis_pkg::CIS_BRANCH_ABS: begin
                            if (i.cond_met) next_pc = i.target; // RULE_06
                        end
                        cis_pkg::CIS_BRANCH_IND: begin
                            if (i.cond_met) next_pc = regs[i.reg_idx]; // RULE_06
                        end
                        cis_pkg::CIS_BRANCH_REL: begin
                            if (i.cond_met) next_pc = rel_pc; // RULE_06
                        end
                        cis_pkg::CIS_INTER_SEGMENT_BRANCH: begin
                            next_csp = i.segment; // RULE_07
                            next_pc  = i.target; // RULE_07
                        end
                        cis_pkg::CIS_ENTRY_ABS,
                        cis_pkg::CIS_ENTRY_IND,
                        cis_pkg::CIS_ENTRY_REL: begin
                            // Failed condition leaves the stack untouched
                            if (i.cond_met) begin
                                mem_wr        = 1'b1; // RULE_08
                                mem_byte_addr = sp - cis_pkg::STACK_STEP;
                                mem_wdata     = seq_pc;
                                next_sp       = sp - cis_pkg::STACK_STEP;
                                next_pc       = (i.op == cis_pkg::CIS_ENTRY_ABS) ? i.target :
                                                (i.op == cis_pkg::CIS_ENTRY_IND) ?
                                                regs[i.reg_idx] : rel_pc; // RULE_08
                            end
                        end
                        cis_pkg::CIS_FAR_SUBROUTINE_ENTRY,
                        cis_pkg::CIS_SOFTWARE_TRAP: begin
                            // Segment first, offset on the next cycle
                            mem_wr        = 1'b1; // RULE_09
                            mem_byte_addr = sp - cis_pkg::STACK_STEP;
                            mem_wdata     = {8'h00, csp};
                            next_sp       = sp - cis_pkg::STACK_STEP;
                            next_ret_ip   = seq_pc;
                            next_st       = ST_PUSH_IP;
                            if (i.op == cis_pkg::CIS_SOFTWARE_TRAP) begin
                                next_csp = cis_pkg::CSP_RESET; // RULE_15
                                next_pc  = {7'h00, i.trap_num, 2'b00}; // RULE_15
                            end else begin
                                next_csp = i.segment; // RULE_09
                                next_pc  = i.target; // RULE_09
                            end
                        end
                        cis_pkg::CIS_PUSH_THEN_SUBROUTINE_ENTRY: begin
                            mem_wr        = 1'b1; // RULE_10
                            mem_byte_addr = sp - cis_pkg::STACK_STEP;
                            mem_wdata     = regs[i.reg_idx];
                            next_sp       = sp - cis_pkg::STACK_STEP;
                            next_ret_ip   = seq_pc;
                            next_pc       = i.target; // RULE_10
                            next_st       = ST_PUSH_IP;
                        end
                        cis_pkg::CIS_CONTEXT_SWITCH_PUSH_LOAD: begin
                            mem_wr        = 1'b1; // RULE_11
                            mem_byte_addr = sp - cis_pkg::STACK_STEP;
                            mem_wdata     = regs[i.reg_idx];
                            next_sp       = sp - cis_pkg::STACK_STEP;
                            next_regs[i.reg_idx] = i.imm; // RULE_11
                        end
                        cis_pkg::CIS_PUSH: begin
                            mem_wr        = 1'b1; // RULE_12
                            mem_byte_addr = sp - cis_pkg::STACK_STEP;
                            mem_wdata     = regs[i.reg_idx];
                            next_sp       = sp - cis_pkg::STACK_STEP; // RULE_12
                        end
                        cis_pkg::CIS_POP,
                        cis_pkg::CIS_NEAR_SUBROUTINE_EXIT,
                        cis_pkg::CIS_FAR_SUBROUTINE_EXIT,
                        cis_pkg::CIS_SUBROUTINE_EXIT_WITH_POP: begin
                            // Read data is registered, so the pop completes later
                            mem_rd        = 1'b1; // RULE_12
                            next_sp       = sp + cis_pkg::STACK_STEP;
                            next_pend_op  = i.op;
                            next_pend_reg = i.reg_idx;
                            next_st       = ST_POP1;
                        end
                        cis_pkg::CIS_POWER_DOWN_ENTRY: begin
                            // Ignored while NMI is high: no way to wake otherwise
                            if (!nmi_sync) next_pwr = 1'b1; // RULE_16
                        end
                        cis_pkg::CIS_END_OF_INIT_SIGNAL: begin
                            next_init_done = 1'b1; // RULE_17
                        end
                        cis_pkg::CIS_REGISTER_SPACE_PREFIX: begin
                            next_ovr = '{active: 1'b1, page: 1'b0, segment: 1'b0,
                                         reg_ext: 1'b1, value: 16'h0000,
                                         left: i.seq_len}; // RULE_19
                        end
                        cis_pkg::CIS_PAGE_OVERRIDE_PREFIX,
                        cis_pkg::CIS_SEGMENT_OVERRIDE_PREFIX: begin
                            next_ovr = '{active: 1'b1,
                                         page: (i.op == cis_pkg::CIS_PAGE_OVERRIDE_PREFIX),
                                         segment: (i.op == cis_pkg::CIS_SEGMENT_OVERRIDE_PREFIX),
                                         reg_ext: i.with_reg,
                                         value: i.long_form ? i.imm : regs[i.reg_idx],
                                         left: i.seq_len}; // RULE_18
                        end
                        default: begin
                        end
                    endcase
                end
            end
            ST_PUSH_IP: begin
                mem_wr        = 1'b1; // RULE_09
                mem_byte_addr = sp - cis_pkg::STACK_STEP;
                mem_wdata     = ret_ip; // RULE_10
                next_sp       = sp - cis_pkg::STACK_STEP;
                next_st       = ST_IDLE;
            end
            ST_POP1: begin
                next_st = ST_IDLE;
                if (pend_op == cis_pkg::CIS_POP) begin
                    next_regs[pend_reg] = mem_rdata; // RULE_12
                end else begin
                    next_pc = mem_rdata; // RULE_14
                end
                if (pend_op == cis_pkg::CIS_FAR_SUBROUTINE_EXIT ||
                    pend_op == cis_pkg::CIS_SUBROUTINE_EXIT_WITH_POP) begin
                    mem_rd  = 1'b1;
                    next_sp = sp + cis_pkg::STACK_STEP;
                    next_st = ST_POP2;
                end
            end
            ST_POP2: begin
                next_st = ST_IDLE;
                if (pend_op == cis_pkg::CIS_FAR_SUBROUTINE_EXIT) begin
                    next_csp = mem_rdata[7:0]; // RULE_14
                end else begin
                    next_regs[pend_reg] = mem_rdata; // RULE_13
                end
            end
        endcase
    end

    always_ff @(posedge ref_clk_in) begin
        nmi_meta <= nmi_n_in;
        nmi_sync <= nmi_meta;
        if (sys_rst_in) begin
            st              <= ST_IDLE;
            pc              <= cis_pkg::PC_RESET;
            csp             <= cis_pkg::CSP_RESET;
            sp              <= cis_pkg::SP_RESET;
            ret_ip          <= 16'h0000;
            pend_op         <= cis_pkg::CIS_NOP;
            pend_reg        <= 4'h0;
            pwr             <= 1'b0;
            init_done       <= 1'b0;
            ovr             <= '0;
            reg_rd_data_out <= 16'h0000;
            for (int k = 0; k < cis_pkg::NUM_REGS; k++) begin
                regs[k] <= 16'h0000;
            end
        end else begin
            st              <= next_st;
            pc              <= next_pc;
            csp             <= next_csp;
            sp              <= next_sp;
            ret_ip          <= next_ret_ip;
            pend_op         <= next_pend_op;
            pend_reg        <= next_pend_reg;
            pwr             <= next_pwr;
            init_done       <= next_init_done;
            ovr             <= next_ovr;
            reg_rd_data_out <= next_reg_rd;
            regs            <= next_regs;
        end
    end

endmodule

`default_nettype wire

// >>> dv/cis_exec_properties.sv
`timescale 1ns/10ps
`default_nettype none
module cis_exec_checker (
    // Clock and reset
    input wire logic                ref_clk_in,
    input wire logic                sys_rst_in,
    // Instruction port
    input wire logic                instr_valid_in,
    input wire cis_pkg::cis_instr_t instr_in,
    input wire logic                instr_ready_out,
    // Pins and state
    input wire logic                reset_output_pin_n_out,
    input wire logic                power_down_out,
    input wire logic [15:0]         pc_out,
    input wire logic [7:0]          csp_out,
    input wire logic [15:0]         sp_out,
    input wire cis_pkg::cis_ovr_t   ovr_out
);
    wire logic acc = instr_valid_in && instr_ready_out;
    default clocking cb @(posedge ref_clk_in); endclocking
    default disable iff (sys_rst_in);
    sequence s_far_acc;
        acc && instr_in.op == cis_pkg::CIS_FAR_SUBROUTINE_ENTRY;
    endsequence
    sequence s_one_stall;
        !instr_ready_out ##1 instr_ready_out;
    endsequence
    property p_far; s_far_acc |=> s_one_stall; endproperty
    a_far: assert property (p_far) else $error("far entry timing");
    property p_pd; power_down_out |-> !instr_ready_out; endproperty
    a_pd: assert property (p_pd) else $error("ready in power down");
    property p_pdc; $rose(power_down_out) |-> $past(acc) && $past(instr_in.op) == cis_pkg::CIS_POWER_DOWN_ENTRY; endproperty
    a_pdc: assert property (p_pdc) else $error("power down cause");
    property p_rp; $rose(reset_output_pin_n_out) |-> $past(acc) && $past(instr_in.op) == cis_pkg::CIS_END_OF_INIT_SIGNAL; endproperty
    a_rp: assert property (p_rp) else $error("reset pin cause");
    property p_push; acc && instr_in.op == cis_pkg::CIS_PUSH |=> sp_out == $past(sp_out) - 16'h0002; endproperty
    a_push: assert property (p_push) else $error("push sp");
    property p_trap; acc && instr_in.op == cis_pkg::CIS_SOFTWARE_TRAP |=> pc_out == {7'h00, $past(instr_in.trap_num), 2'h0} && csp_out == 8'h00; endproperty
    a_trap: assert property (p_trap) else $error("trap vector");
    property p_seg; acc && instr_in.op == cis_pkg::CIS_INTER_SEGMENT_BRANCH |=> pc_out == $past(instr_in.target) && csp_out == $past(instr_in.segment); endproperty
    a_seg: assert property (p_seg) else $error("segment branch");
    property p_nbr; acc && instr_in.op == cis_pkg::CIS_BRANCH_ABS && !instr_in.cond_met |=> pc_out == $past(pc_out) + 16'h0004; endproperty
    a_nbr: assert property (p_nbr) else $error("untaken branch");
    property p_pfx; acc && instr_in.op == cis_pkg::CIS_REGISTER_SPACE_PREFIX |=> ovr_out.active && ovr_out.reg_ext && ovr_out.left == $past(instr_in.seq_len); endproperty
    a_pfx: assert property (p_pfx) else $error("register prefix");
endmodule
bind cis_exec cis_exec_checker u_chk (.ref_clk_in(ref_clk_in), .sys_rst_in(sys_rst_in),
    .instr_valid_in(instr_valid_in), .instr_in(instr_in), .instr_ready_out(instr_ready_out),
    .reset_output_pin_n_out(reset_output_pin_n_out), .power_down_out(power_down_out),
    .pc_out(pc_out), .csp_out(csp_out), .sp_out(sp_out), .ovr_out(ovr_out));
`default_nettype wire

// >>> dv/tb.sv
`timescale 1ns/10ps
`default_nettype none
module tb;
    logic                ref_clk_in = 1'b0;
    logic                sys_rst_in = 1'b1;
    logic                vld = 1'b0;
    logic                nmi_n = 1'b1;
    logic [3:0]          ridx = 4'h0;
    cis_pkg::cis_instr_t ins = '0;
    logic                rdy, rpin, pd;
    logic [15:0]         pc, sp, rdat;
    logic [7:0]          csp;
    cis_pkg::cis_ovr_t   ovr;
    int                  n_fail = 0;
    int                  compares = 0;
    int                  cyc = 0;
    always #5 ref_clk_in = ~ref_clk_in;
    cis_exec DUT (.ref_clk_in(ref_clk_in), .sys_rst_in(sys_rst_in), .instr_valid_in(vld),
        .instr_in(ins), .instr_ready_out(rdy), .nmi_n_in(nmi_n),
        .reset_output_pin_n_out(rpin), .power_down_out(pd), .pc_out(pc), .csp_out(csp),
        .sp_out(sp), .ovr_out(ovr), .reg_rd_idx_in(ridx), .reg_rd_data_out(rdat));
    task end_sim();
        $display("fails %0d compares %0d", n_fail, compares);
        if (n_fail == 0 && compares > 0) begin
            $display("RESULT: PASS");
        end else begin
            $display("RESULT: FAIL");
        end
        $finish;
    endtask
    always @(posedge ref_clk_in) begin
        cyc <= cyc + 1;
        if (cyc == 2000) begin
            n_fail++;
            end_sim();
        end
    end
    task chk(input logic [23:0] got, input logic [23:0] exp, input string m);
        compares++;
        if (got !== exp) begin
            n_fail++;
            $display("CHECK FAILED at %0t: %s got %h exp %h", $time, m, got, exp);
        end
    endtask
    // Called just after an edge with ready high; returns once ready is back, or after at most 8 further edges
    task go(input cis_pkg::cis_op_t op);
        int n;
        ins.op = op;
        vld = 1'b1;
        @(posedge ref_clk_in);
        #1;
        vld = 1'b0;
        for (n = 0; n == 0 || (n < 8 && rdy !== 1'b1); n++) begin
            @(posedge ref_clk_in);
            #1;
        end
    endtask
    task chk_reg(input logic [3:0] i, input logic [15:0] e, input string m);
        ridx = i;
        @(posedge ref_clk_in);
        #1;
        chk(rdat, e, m);
    endtask
    task t_load_and_moves();
        ins.reg_idx = 4'h1;
        ins.imm = 16'h0080;
        go(cis_pkg::CIS_CONTEXT_SWITCH_PUSH_LOAD);
        chk(sp, 16'hFBFE, "ctx sp");
        chk_reg(4'h1, 16'h0080, "ctx reg");
        ins.reg_idx = 4'h2;
        ins.long_form = 1'b1;
        ins.imm = 16'h1280;
        go(cis_pkg::CIS_BYTE_TO_WORD_SIGNED_MOVE);
        chk_reg(4'h2, 16'hFF80, "sign move");
        go(cis_pkg::CIS_BYTE_TO_WORD_UNSIGNED_MOVE);
        chk_reg(4'h2, 16'h0080, "zero move");
        chk(pc, 16'h000C, "move len");
    endtask
    task t_bit_branches();
        ins.reg_idx = 4'h1;
        ins.bit_idx = 4'h7;
        ins.rel = 8'hFE;
        go(cis_pkg::CIS_BRANCH_AND_CLEAR_BIT);
        chk(pc, 16'h000C, "clear branch pc");
        chk_reg(4'h1, 16'h0000, "clear bit");
        ins.rel = 8'h04;
        go(cis_pkg::CIS_BRANCH_AND_SET_BIT);
        chk(pc, 16'h0018, "set branch pc");
        chk_reg(4'h1, 16'h0080, "set bit");
        go(cis_pkg::CIS_BRANCH_BIT_CLEAR);
        chk(pc, 16'h001C, "bit test fall");
        chk_reg(4'h1, 16'h0080, "bit kept");
        ins.cond_met = 1'b0;
        ins.target = 16'h0100;
        go(cis_pkg::CIS_BRANCH_ABS);
        go(cis_pkg::CIS_ENTRY_ABS);
        chk(sp, 16'hFBFE, "no stack");
        ins.cond_met = 1'b1;
        go(cis_pkg::CIS_BRANCH_ABS);
        chk(pc, 16'h0100, "taken abs");
    endtask
    task t_stack_and_far();
        go(cis_pkg::CIS_PUSH);
        ins.reg_idx = 4'h3;
        go(cis_pkg::CIS_POP);
        chk(sp, 16'hFBFE, "pop sp");
        chk_reg(4'h3, 16'h0080, "pop reg");
        ins.segment = 8'h05;
        ins.target = 16'h0200;
        go(cis_pkg::CIS_FAR_SUBROUTINE_ENTRY);
        chk({csp, sp}, 24'h05FBFA, "far entry");
        go(cis_pkg::CIS_FAR_SUBROUTINE_EXIT);
        chk({csp, pc}, 24'h000108, "far exit");
        ins.segment = 8'h03;
        go(cis_pkg::CIS_INTER_SEGMENT_BRANCH);
        ins.trap_num = 7'h05;
        go(cis_pkg::CIS_SOFTWARE_TRAP);
        chk({csp, pc}, 24'h000014, "trap");
        go(cis_pkg::CIS_PUSH_THEN_SUBROUTINE_ENTRY);
        ins.reg_idx = 4'h4;
        go(cis_pkg::CIS_SUBROUTINE_EXIT_WITH_POP);
        chk(pc, 16'h0018, "push_then_subroutine_entry ret");
        chk_reg(4'h4, 16'h0080, "pop reg 2");
    endtask
    task t_prefix_and_pins();
        ins.seq_len = 3'h2;
        go(cis_pkg::CIS_REGISTER_SPACE_PREFIX);
        go(cis_pkg::CIS_NOP);
        chk(ovr.left, 16'h0001, "left");
        go(cis_pkg::CIS_NOP);
        chk(ovr.active, 16'h0000, "closed");
        ins.imm = 16'h1234;
        go(cis_pkg::CIS_PAGE_OVERRIDE_PREFIX);
        chk(ovr.value, 16'h1234, "page value");
        chk({ovr.active, ovr.page}, 16'h0003, "page on");
        go(cis_pkg::CIS_POWER_DOWN_ENTRY);
        chk(pd, 16'h0000, "nmi high");
        go(cis_pkg::CIS_END_OF_INIT_SIGNAL);
        chk(rpin, 16'h0001, "init pin");
        nmi_n = 1'b0;
        repeat (3) @(posedge ref_clk_in);
        #1;
        go(cis_pkg::CIS_POWER_DOWN_ENTRY);
        chk({pd, rdy}, 16'h0002, "power down");
    endtask
    initial begin
        repeat (2) @(posedge ref_clk_in);
        #1;
        sys_rst_in = 1'b0;
        chk({rpin, csp, rdy}, 16'h0001, "reset pins");
        chk(sp, 16'hFC00, "reset sp");
        t_load_and_moves();
        t_bit_branches();
        t_stack_and_far();
        t_prefix_and_pins();
        end_sim();
    end
endmodule
`default_nettype wire
